// *** hw/iosit_pkg.sv ***
// Purpose: Shared constants for the peripheral status, edge and timer unit.
// Assumes: One phi-two cycle per clk_i edge; zero-page byte accesses from the core.
// Notes:   Flag, edge and timer rules listed below.
// Behaviour
// R1 - Status byte lives at zero-page 8F
// R2 - Flag, enable and mode bit layout fixed
// R3 - Rising edge sets bit 6; write 89 clears
// R4 - Falling edge sets bit 5; write 8A clears
// R5 - Source holds edge pulses two clocks minimum
// R6 - Detectors see own port output transitions
// R7 - Underflow flag sets in every timer mode
// R8 - Reset clears flag, not counter or latch
// R9 - Enable bit one permits, zero masks source
// R10 - Mode bits reset to zero
// R11 - Underflow flag with bit 4 requests interrupt
// R12 - Edge flags request via bits 3, 2
// R13 - Request is OR of flag-enable products
// R14 - Request holds until enabled flags cleared
// R15 - Maskable vector at FFE and FFF
// R16 - NMI falling-edge, vector at FFA, FFB
// R17 - Counter loads only from latch transfer
// R18 - Latch bytes write-only, counter bytes read-only
// R19 - No direction registers; inputs left released high
// R20 - All four ports sit in page zero
// R21 - Modes 00/01 count clocks; 01 toggles pin
// R22 - Mode 10 counts pin rises; 11 gated low
// R23 - Underflow from 0000 reloads from latch
// R24 - Low counter read or 88 write clears
// R25 - Edge inputs synchronised before comparison
package iosit_pkg;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned VEC_W  = 12;
   localparam int unsigned NPORT  = 4;

   localparam logic [ADDR_W-1:0] PORT_ONE_ADDR      = 8'h80;
   localparam logic [ADDR_W-1:0] PORT_TWO_ADDR      = 8'h81;
   localparam logic [ADDR_W-1:0] PORT_THREE_ADDR    = 8'h82;
   localparam logic [ADDR_W-1:0] PORT_FOUR_ADDR     = 8'h83;
   localparam logic [ADDR_W-1:0] COUNTER_HIGH_ADDR  = 8'h84;
   localparam logic [ADDR_W-1:0] COUNTER_LOW_ADDR   = 8'h85;
   localparam logic [ADDR_W-1:0] LATCH_LOW_ADDR     = 8'h86;
   localparam logic [ADDR_W-1:0] LATCH_HIGH_ADDR    = 8'h88;
   localparam logic [ADDR_W-1:0] CLEAR_RISE_ADDR    = 8'h89;
   localparam logic [ADDR_W-1:0] CLEAR_FALL_ADDR    = 8'h8a;
   localparam logic [ADDR_W-1:0] STATUS_ADDR        = 8'h8f;

   localparam int unsigned UFLOW_BIT   = 7;
   localparam int unsigned RISE_BIT    = 6;
   localparam int unsigned FALL_BIT    = 5;
   localparam int unsigned EN_UFLOW_BIT = 4;
   localparam int unsigned EN_RISE_BIT = 3;
   localparam int unsigned EN_FALL_BIT = 2;
   localparam int unsigned MODE_HI_BIT = 1;
   localparam int unsigned MODE_LO_BIT = 0;

   localparam logic [DATA_W-1:0] STATUS_RST = 8'h00;
   localparam logic [DATA_W-1:0] PORT_RST   = 8'hff;

   localparam logic [VEC_W-1:0] IRQ_VEC_ADDR = 12'hffe;
   localparam logic [VEC_W-1:0] NMI_VEC_ADDR = 12'hffa;

   typedef logic [1:0] iosit_mode_type;
   localparam iosit_mode_type MODE_FREE_HIGH   = 2'h0;
   localparam iosit_mode_type MODE_FREE_TOGGLE = 2'h1;
   localparam iosit_mode_type MODE_EVENT_COUNT = 2'h2;
   localparam iosit_mode_type MODE_PULSE_WIDTH = 2'h3;
endpackage

// *** hw/iosit_link_if.sv ***
// Purpose: Carrier between the core block, the timer and the edge detectors.
// Assumes: All members except edge_pins live in the clk_i domain.
// Notes:   Core modport drives controls, sub-blocks answer.
`timescale 1ns/1ps
`default_nettype none
interface iosit_link_if;
   import iosit_pkg::*;
   iosit_mode_type      mode;
   logic                latch_low_wr;
   logic                latch_high_wr;
   logic [DATA_W-1:0]   wdata;
   logic [2*DATA_W-1:0] count;
   logic                underflow;
   logic                counter_pin_in;
   logic                counter_pin_out;
   logic                counter_pin_oe;
   logic [1:0]          edge_pins;
   logic                rise_evt;
   logic                fall_evt;

   modport core  (output mode, latch_low_wr, latch_high_wr, wdata, counter_pin_in, edge_pins,
                  input  count, underflow, counter_pin_out, counter_pin_oe, rise_evt, fall_evt);
   modport timer (input  mode, latch_low_wr, latch_high_wr, wdata, counter_pin_in,
                  output count, underflow, counter_pin_out, counter_pin_oe);
   modport edges (input  edge_pins, output rise_evt, fall_evt);
endinterface
`default_nettype wire

// *** hw/iosit_edge.sv ***
// Purpose: Synchronise the two edge pins and emit one-cycle edge events.
// Assumes: Pins may be asynchronous; pulses held two clocks or more.
// Notes:   Third stage keeps history so the sync head feeds only its successor.
`timescale 1ns/1ps
`default_nettype none
module iosit_edge (
   input  wire logic   clk_i,
   input  wire logic   rst_b_i,
   iosit_link_if.edges lnk
);
   import iosit_pkg::*;

   logic [1:0] sync_head;
   logic [1:0] sync_tail;
   logic [1:0] history;

   // Reset to the pull-up level, so release brings no false edge
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         sync_head <= 2'h3;
         sync_tail <= 2'h3;
         history   <= 2'h3;
      end else begin
         sync_head <= lnk.edge_pins; // see R25
         sync_tail <= sync_head;
         history   <= sync_tail;
      end
   end

   assign lnk.rise_evt = sync_tail[0] & ~history[0]; // see R3
   assign lnk.fall_evt = ~sync_tail[1] & history[1]; // see R4

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_rise_single_cycle: assert property (lnk.rise_evt |=> !lnk.rise_evt) // see R25
      else $error("rise event lasted more than one cycle");
   chk_fall_after_sync: assert property (
      $fell(lnk.edge_pins[1]) ##1 !lnk.edge_pins[1] |-> ##1 lnk.fall_evt) // see R4
      else $error("held falling edge not reported after sync");
endmodule
`default_nettype wire

// *** hw/iosit_timer.sv ***
// Purpose: 16-bit down counter with latch reload and counter pin logic.
// Assumes: Counter pin input is synchronous to clk_i.
// Notes:   Counter and latch have no reset; values are unknown until written.
`timescale 1ns/1ps
`default_nettype none
module iosit_timer (
   input  wire logic   clk_i,
   input  wire logic   rst_b_i,
   iosit_link_if.timer lnk
);
   import iosit_pkg::*;

   logic [2*DATA_W-1:0] count;
   logic [DATA_W-1:0]   latch_low_byte;
   logic [DATA_W-1:0]   latch_high_byte;
   logic                pin_prev;
   logic                pin_level;
   logic                pin_oe;
   logic                pin_out;

   wire logic pin_rise = lnk.counter_pin_in & ~pin_prev;
   wire logic count_en = (lnk.mode == MODE_EVENT_COUNT) ? pin_rise :  // see R22
                         (lnk.mode == MODE_PULSE_WIDTH) ? ~lnk.counter_pin_in : 1'b1; // see R21
   // A transfer in the same cycle outranks counting
   wire logic underflow = count_en & (count == 16'h0000) & ~lnk.latch_high_wr; // see R7
   wire logic [2*DATA_W-1:0] next_count =
      lnk.latch_high_wr ? {lnk.wdata, latch_low_byte} :     // see R17
      underflow         ? {latch_high_byte, latch_low_byte} : // see R23
      count_en          ? count - 16'h0001 : count;
   wire logic toggle = (lnk.mode == MODE_FREE_TOGGLE) & (underflow | lnk.latch_high_wr);
   wire logic next_level = (lnk.mode == MODE_FREE_TOGGLE) ? pin_level ^ toggle : 1'b1;

   // No reset on counter and latch, on purpose
   always_ff @(posedge clk_i) begin
      count <= next_count; // see R8
      if (lnk.latch_low_wr) begin
         latch_low_byte <= lnk.wdata;
      end
      if (lnk.latch_high_wr) begin
         latch_high_byte <= lnk.wdata;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pin_prev  <= 1'b1;
         pin_level <= 1'b1;
         pin_oe    <= 1'b0;
         pin_out   <= 1'b0;
      end else begin
         pin_prev  <= lnk.counter_pin_in;
         pin_level <= next_level; // see R21
         pin_oe    <= ~next_level;
         pin_out   <= 1'b0;
      end
   end

   assign lnk.count     = count;
   assign lnk.underflow = underflow;
   assign lnk.counter_pin_oe   = pin_oe;
   assign lnk.counter_pin_out  = pin_out;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_reload_not_wrap: assert property (
      underflow && !lnk.latch_low_wr |=> count == {latch_high_byte, latch_low_byte}) // see R23
      else $error("counter did not reload from latch on underflow");
   chk_mode00_pin_high: assert property (lnk.mode == MODE_FREE_HIGH |=> !pin_oe) // see R21
      else $error("counter pin driven in mode 00");
   chk_mode11_hold: assert property (
      lnk.mode == MODE_PULSE_WIDTH && lnk.counter_pin_in && !lnk.latch_high_wr
      |=> $stable(count)) // see R22
      else $error("counter moved while pulse-width pin high");
endmodule
`default_nettype wire

// *** hw/iosit_unit.sv ***
// Purpose: Zero-page status byte, edge flags, interrupt request, ports, timer.
// Assumes: One zero-page access per clk_i; read data answers one cycle later.
// Notes:   Port pins are open drain: a written zero pulls the pin low.
`timescale 1ns/1ps
`default_nettype none
module iosit_unit (
   input  wire logic                            clk_i,
   input  wire logic                            rst_b_i,
   input  wire logic [iosit_pkg::ADDR_W-1:0]    addr_i,
   input  wire logic                            wr_en_i,
   input  wire logic                            rd_en_i,
   input  wire logic [iosit_pkg::DATA_W-1:0]    wdata_i,
   output logic      [iosit_pkg::DATA_W-1:0]    rdata_o,
   input  wire logic [iosit_pkg::NPORT-1:0][7:0] port_in_i,
   output logic      [iosit_pkg::NPORT-1:0][7:0] port_out_o,
   output logic      [iosit_pkg::NPORT-1:0][7:0] port_oe_o,
   input  wire logic                            counter_pin_in_i,
   output logic                                 counter_pin_out_o,
   output logic                                 counter_pin_oe_o,
   input  wire logic                            nmi_b_i,
   output logic                                 irq_req_o,
   output logic                                 nmi_req_o,
   output logic      [iosit_pkg::VEC_W-1:0]     irq_vector_o,
   output logic      [iosit_pkg::VEC_W-1:0]     nmi_vector_o
);
   import iosit_pkg::*;

   iosit_link_if lnk ();

   iosit_timer u_timer (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .lnk     (lnk.timer)
   );

   iosit_edge u_edge (
      .clk_i   (clk_i),
      .rst_b_i (rst_b_i),
      .lnk     (lnk.edges)
   );

   // Control and status state
   logic                         uflow_flag;
   logic                         rise_flag;
   logic                         fall_flag;
   logic [2:0]                   irq_enable;
   iosit_mode_type               mode;
   logic                         nmi_prev;

   // Address decode
   wire logic wr_status    = wr_en_i & (addr_i == STATUS_ADDR); // see R1
   wire logic wr_clr_rise  = wr_en_i & (addr_i == CLEAR_RISE_ADDR); // see R3
   wire logic wr_clr_fall  = wr_en_i & (addr_i == CLEAR_FALL_ADDR); // see R4
   wire logic wr_latch_low = wr_en_i & (addr_i == LATCH_LOW_ADDR); // see R18
   wire logic wr_latch_hi  = wr_en_i & (addr_i == LATCH_HIGH_ADDR); // see R24
   wire logic rd_cnt_low   = rd_en_i & (addr_i == COUNTER_LOW_ADDR); // see R24
   wire logic [NPORT-1:0] wr_port;

   genvar gp;
   generate
      for (gp = 0; gp < NPORT; gp++) begin : g_port_dec
         // Ports occupy consecutive page-zero bytes
         assign wr_port[gp] = wr_en_i &
            (addr_i == PORT_ONE_ADDR + ADDR_W'(gp)); // see R20
      end
   endgenerate

   // Timer and edge hookup
   assign lnk.mode          = mode;
   assign lnk.latch_low_wr  = wr_latch_low;
   assign lnk.latch_high_wr = wr_latch_hi;
   assign lnk.wdata         = wdata_i;
   assign lnk.counter_pin_in       = counter_pin_in_i;
   // Pin level, not written data, so own output writes also trip the detectors
   assign lnk.edge_pins     = port_in_i[0][1:0]; // see R6

   // Flags: hardware set wins over any clear in the same cycle
   wire logic next_uflow = lnk.underflow |
                           (uflow_flag & ~(rd_cnt_low | wr_latch_hi)); // see R7
   wire logic next_rise  = lnk.rise_evt | (rise_flag & ~wr_clr_rise); // see R3
   wire logic next_fall  = lnk.fall_evt | (fall_flag & ~wr_clr_fall); // see R4

   // Status byte image
   wire logic [DATA_W-1:0] status_byte = {uflow_flag, rise_flag, fall_flag,
                                          irq_enable, mode}; // see R2

   // Interrupt request from current flags and enables
   wire logic [2:0] irq_terms = {uflow_flag, rise_flag, fall_flag} & irq_enable; // see R9 see R12
   wire logic next_irq = |irq_terms; // see R13 see R14

   wire logic nmi_fall = nmi_prev & ~nmi_b_i; // see R16

   // Read mux; write-only and unmapped bytes read as zero
   logic [DATA_W-1:0] next_rdata;
   always_comb begin
      next_rdata = 8'h00;
      unique case (addr_i)
         PORT_ONE_ADDR:     next_rdata = port_in_i[0];
         PORT_TWO_ADDR:     next_rdata = port_in_i[1];
         PORT_THREE_ADDR:   next_rdata = port_in_i[2];
         PORT_FOUR_ADDR:    next_rdata = port_in_i[3];
         COUNTER_HIGH_ADDR: next_rdata = lnk.count[15:8]; // see R18
         COUNTER_LOW_ADDR:  next_rdata = lnk.count[7:0];
         STATUS_ADDR:       next_rdata = status_byte; // see R1
         default:           next_rdata = 8'h00;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         uflow_flag <= STATUS_RST[UFLOW_BIT]; // see R8
         rise_flag  <= STATUS_RST[RISE_BIT];
         fall_flag  <= STATUS_RST[FALL_BIT];
         irq_enable <= STATUS_RST[EN_UFLOW_BIT:EN_FALL_BIT];
         mode       <= STATUS_RST[MODE_HI_BIT:MODE_LO_BIT]; // see R10
      end else begin
         uflow_flag <= next_uflow;
         rise_flag  <= next_rise;
         fall_flag  <= next_fall;
         if (wr_status) begin
            // Flags ignore status writes; only their clear strobes drop them
            irq_enable <= wdata_i[EN_UFLOW_BIT:EN_FALL_BIT];
            mode       <= wdata_i[MODE_HI_BIT:MODE_LO_BIT];
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         port_out_o <= '0;
         // Reset leaves every line released to its pull-up
         port_oe_o  <= ~{NPORT{PORT_RST}};
      end else begin
         for (int i = 0; i < NPORT; i++) begin
            if (wr_port[i]) begin
               port_oe_o[i] <= ~wdata_i; // see R19
            end
         end
         port_out_o <= '0;
      end
   end

   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_o      <= 8'h00;
         irq_req_o    <= 1'b0;
         nmi_req_o    <= 1'b0;
         nmi_prev     <= 1'b1;
         counter_pin_out_o   <= 1'b0;
         counter_pin_oe_o    <= 1'b0;
         irq_vector_o <= IRQ_VEC_ADDR; // see R15
         nmi_vector_o <= NMI_VEC_ADDR; // see R16
      end else begin
         if (rd_en_i) begin
            rdata_o <= next_rdata;
         end
         irq_req_o    <= next_irq; // see R11
         nmi_req_o    <= nmi_fall;
         nmi_prev     <= nmi_b_i;
         counter_pin_out_o   <= lnk.counter_pin_out;
         counter_pin_oe_o    <= lnk.counter_pin_oe;
         irq_vector_o <= IRQ_VEC_ADDR;
         nmi_vector_o <= NMI_VEC_ADDR;
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   chk_irq_uflow_src: assert property (
      uflow_flag && irq_enable[2] |=> irq_req_o) // see R11
      else $error("underflow flag enabled but no request");
   chk_irq_edge_src: assert property (
      (rise_flag && irq_enable[1]) || (fall_flag && irq_enable[0]) |=> irq_req_o) // see R12
      else $error("edge flag enabled but no request");
   chk_irq_masked: assert property (
      irq_terms == 3'h0 |=> !irq_req_o) // see R9
      else $error("request raised with all sources masked");
   chk_irq_held_pending: assert property (
      irq_req_o && $past(irq_terms) != 3'h0 && irq_terms != 3'h0 |=> irq_req_o) // see R14
      else $error("request dropped while a source still pending");
   chk_rise_clear_89: assert property (
      rise_flag && wr_clr_rise && !lnk.rise_evt |=> !rise_flag) // see R3
      else $error("write to 89 did not clear rising-edge flag");
   chk_fall_set_wins: assert property (
      lnk.fall_evt && wr_clr_fall |=> fall_flag) // see R4
      else $error("falling edge lost against clear strobe");
   chk_uflow_sets: assert property (
      lnk.underflow |=> uflow_flag ##0 status_byte[UFLOW_BIT]) // see R7
      else $error("underflow did not set flag bit 7");
   chk_uflow_clears: assert property (
      uflow_flag && (rd_cnt_low || wr_latch_hi) && !lnk.underflow |=> !uflow_flag) // see R24
      else $error("counter read or latch transfer did not clear flag");
   chk_status_readback: assert property (
      rd_en_i && addr_i == STATUS_ADDR |=> rdata_o == $past(status_byte)) // see R1
      else $error("status byte read back wrong");
   chk_nmi_edge: assert property (
      $fell(nmi_b_i) |=> nmi_req_o ##1 !nmi_req_o || $fell(nmi_b_i)) // see R16
      else $error("nmi falling edge not turned into one pulse");
   chk_mode_write: assert property (
      wr_status |=> mode == $past(wdata_i[1:0]) ##0 irq_enable == $past(wdata_i[4:2])) // see R2
      else $error("status write did not update enables and mode");
   chk_port_release: assert property (
      wr_port[1] && wdata_i == 8'hff |=> port_oe_o[1] == 8'h00) // see R19
      else $error("released port bits still driven");
endmodule
`default_nettype wire

// *** verification/iosit_pin_model.sv ***
// Purpose: Pin-side model of the four open-drain ports and the counter pin.
// Assumes: Pull-ups on every line; the bench may pull any line low.
// Notes:   A released line reads high, never a stale driven level.
`timescale 1ns/1ps
`default_nettype none
module iosit_pin_model (
   input  wire logic [3:0][7:0] port_oe_i,
   input  wire logic [3:0][7:0] ext_low_i,
   input  wire logic            counter_pin_oe_i,
   input  wire logic            counter_pin_ext_low_i,
   output logic      [3:0][7:0] pin_o,
   output logic                 counter_pin_pin_o
);
   // Own drive reaches the edge inputs as well as outside drivers
   assign pin_o      = ~(port_oe_i | ext_low_i);
   assign counter_pin_pin_o = ~(counter_pin_oe_i | counter_pin_ext_low_i);
endmodule
`default_nettype wire

// *** verification/test_io_status_irq_edge_timer_unit.sv ***
// Purpose: Self-checking bench for the status, edge, port and timer unit.
// Assumes: Inputs change on the falling edge; read data one cycle after the strobe.
// Notes:   Latch is loaded first, since the counter wakes up unknown.
`timescale 1ns/1ps
`default_nettype none
module test_io_status_irq_edge_timer_unit;
   import iosit_pkg::*;
   logic                  clk_i, rst_b_i, wr_en_i, rd_en_i;
   logic [ADDR_W-1:0]     addr_i;
   logic [DATA_W-1:0]     wdata_i, rdata_o, v, a;
   logic [NPORT-1:0][7:0] port_in_i, port_out_o, port_oe_o, ext_low;
   logic                  counter_pin_in_i, counter_pin_out_o, counter_pin_oe_o, counter_pin_ext_low;
   logic                  nmi_b_i, irq_req_o, nmi_req_o;
   logic [VEC_W-1:0]      irq_vector_o, nmi_vector_o;
   logic [15:0]           lfsr;
   int                    n_fail, checks;
   int                    cyc = 0;

   iosit_unit iosit_unit_i (
      .clk_i(clk_i), .rst_b_i(rst_b_i), .addr_i(addr_i), .wr_en_i(wr_en_i),
      .rd_en_i(rd_en_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .port_in_i(port_in_i),
      .port_out_o(port_out_o), .port_oe_o(port_oe_o), .counter_pin_in_i(counter_pin_in_i),
      .counter_pin_out_o(counter_pin_out_o), .counter_pin_oe_o(counter_pin_oe_o), .nmi_b_i(nmi_b_i),
      .irq_req_o(irq_req_o), .nmi_req_o(nmi_req_o), .irq_vector_o(irq_vector_o),
      .nmi_vector_o(nmi_vector_o));

   iosit_pin_model iosit_pin_model_i (
      .port_oe_i(port_oe_o), .ext_low_i(ext_low), .counter_pin_oe_i(counter_pin_oe_o),
      .counter_pin_ext_low_i(counter_pin_ext_low), .pin_o(port_in_i), .counter_pin_pin_o(counter_pin_in_i));

   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   function automatic logic [15:0] next_lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   // Flags ignore writes; only enables and mode read back
   function automatic logic [7:0] exp_ctl(input logic [7:0] d);
      return {3'h0, d[4:0]};
   endfunction

   function automatic logic exp_irq(input logic [7:0] s);
      return |(s[7:5] & s[4:2]);
   endfunction

   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(negedge clk_i);
      addr_i  = ad;
      wdata_i = d;
      wr_en_i = 1'b1;
      @(negedge clk_i);
      wr_en_i = 1'b0;
   endtask

   task automatic rd(input logic [7:0] ad, output logic [7:0] d);
      @(negedge clk_i);
      addr_i  = ad;
      rd_en_i = 1'b1;
      @(negedge clk_i);
      rd_en_i = 1'b0;
      d       = rdata_o;
   endtask

   task automatic rdchk(input string name, input logic [7:0] ad, input logic [7:0] exp);
      logic [7:0] d;
      rd(ad, d);
      chk(name, {8'h00, exp}, {8'h00, d});
   endtask

   task automatic irqchk(input string name, input logic [7:0] s);
      chk(name, {15'h0000, exp_irq(s)}, {15'h0000, irq_req_o});
   endtask

   task automatic idle(input int n);
      repeat (n) @(negedge clk_i);
   endtask

   task automatic tally_and_finish;
      if (n_fail == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // Run is a few hundred cycles; ceiling leaves wide margin
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   initial begin
      n_fail = 0;
      checks = 0;
      lfsr = 16'h154a;
      rst_b_i = 1'b0;
      {wr_en_i, rd_en_i, addr_i, wdata_i} = '0;
      ext_low = '0;
      counter_pin_ext_low = 1'b0;
      nmi_b_i = 1'b1;
      idle(3);
      irqchk("irq_rst", 8'h00);
      chk("oe_rst", 16'h0000, {port_oe_o[1], port_oe_o[0]});
      chk("irq_vec", 16'h0ffe, {4'h0, irq_vector_o});
      chk("nmi_vec", 16'h0ffa, {4'h0, nmi_vector_o});
      rst_b_i = 1'b1;
      // Counter is unknown until the latch transfer
      wr(LATCH_LOW_ADDR, 8'hff);
      wr(LATCH_HIGH_ADDR, 8'hff);
      wr(CLEAR_RISE_ADDR, 8'h00);
      wr(CLEAR_FALL_ADDR, 8'h00);
      rdchk("status_rst", STATUS_ADDR, 8'h00);
      for (int i = 0; i < 12; i++) begin
         lfsr = next_lfsr(lfsr);
         v = (i == 0) ? 8'hff : lfsr[7:0];
         wr(STATUS_ADDR, v);
         rdchk("status_rw", STATUS_ADDR, exp_ctl(v));
         irqchk("irq_no_flag", 8'h00);
      end
      rdchk("unmapped", 8'h8b, 8'h00);
      for (int p = 1; p < 4; p++) begin
         lfsr = next_lfsr(lfsr);
         wr(8'(PORT_ONE_ADDR + p), lfsr[7:0]);
         chk("port_oe", {8'h00, ~lfsr[7:0]}, {8'h00, port_oe_o[p]});
         chk("port_out", 16'h0000, {8'h00, port_out_o[p]});
         ext_low[p] = 8'h81;
         rdchk("port_pin", 8'(PORT_ONE_ADDR + p), lfsr[7:0] & 8'h7e);
         ext_low[p] = 8'h00;
         wr(8'(PORT_ONE_ADDR + p), 8'hff);
      end
      wr(STATUS_ADDR, 8'h0c);
      ext_low[0][0] = 1'b1;
      idle(3);
      ext_low[0][0] = 1'b0;
      idle(6);
      rdchk("rise_set", STATUS_ADDR, 8'h4c);
      irqchk("irq_rise", 8'h4c);
      wr(STATUS_ADDR, 8'h04);
      idle(2);
      irqchk("irq_masked", 8'h44);
      wr(STATUS_ADDR, 8'h0c);
      wr(PORT_ONE_ADDR, 8'hfd);
      idle(6);
      rdchk("fall_own", STATUS_ADDR, 8'h6c);
      wr(CLEAR_RISE_ADDR, lfsr[15:8]);
      idle(2);
      irqchk("irq_one_left", 8'h2c);
      rdchk("rise_clr", STATUS_ADDR, 8'h2c);
      wr(CLEAR_FALL_ADDR, lfsr[7:0]);
      idle(2);
      rdchk("fall_clr", STATUS_ADDR, 8'h0c);
      irqchk("irq_none", 8'h0c);
      wr(PORT_ONE_ADDR, 8'hff);
      wr(STATUS_ADDR, 8'h00);
      wr(LATCH_LOW_ADDR, 8'h40);
      wr(LATCH_HIGH_ADDR, 8'h00);
      idle(80);
      rdchk("uf_first", STATUS_ADDR, 8'h80);
      wr(LATCH_HIGH_ADDR, 8'h00);
      rdchk("uf_by_88", STATUS_ADDR, 8'h00);
      idle(80);
      rdchk("uf_set", STATUS_ADDR, 8'h80);
      wr(STATUS_ADDR, 8'h10);
      idle(2);
      irqchk("irq_uf", 8'h90);
      rdchk("reload_hi", COUNTER_HIGH_ADDR, 8'h00);
      rd(COUNTER_LOW_ADDR, a);
      rdchk("uf_by_rd", STATUS_ADDR, 8'h10);
      idle(1);
      irqchk("irq_uf_clr", 8'h10);
      wr(STATUS_ADDR, 8'h02);
      rd(COUNTER_LOW_ADDR, a);
      wr(COUNTER_LOW_ADDR, 8'h00);
      wr(COUNTER_HIGH_ADDR, 8'hff);
      rdchk("no_direct", COUNTER_LOW_ADDR, a);
      rdchk("latch_wo", LATCH_LOW_ADDR, 8'h00);
      repeat (3) begin
         counter_pin_ext_low = 1'b1;
         idle(2);
         counter_pin_ext_low = 1'b0;
         idle(2);
      end
      rdchk("event_cnt", COUNTER_LOW_ADDR, a - 8'h03);
      wr(STATUS_ADDR, 8'h03);
      idle(4);
      rdchk("gate_hold", COUNTER_LOW_ADDR, a - 8'h03);
      counter_pin_ext_low = 1'b1;
      idle(4);
      counter_pin_ext_low = 1'b0;
      rdchk("gate_count", COUNTER_LOW_ADDR, a - 8'h07);
      wr(STATUS_ADDR, 8'h01);
      chk("counter_pin_pre", 16'h0000, {15'h0000, counter_pin_oe_o});
      wr(LATCH_HIGH_ADDR, 8'h00);
      idle(3);
      chk("counter_pin_toggle", 16'h0001, {15'h0000, counter_pin_oe_o});
      idle(70);
      chk("counter_pin_uf_toggle", 16'h0000, {15'h0000, counter_pin_oe_o});
      wr(STATUS_ADDR, 8'h00);
      idle(2);
      chk("counter_pin_high", 16'h0000, {14'h0000, counter_pin_oe_o, counter_pin_out_o});
      nmi_b_i = 1'b0;
      idle(1);
      chk("nmi_pulse", 16'h0001, {15'h0000, nmi_req_o});
      idle(1);
      chk("nmi_once", 16'h0000, {15'h0000, nmi_req_o});
      nmi_b_i = 1'b1;
      idle(2);
      tally_and_finish();
   end
endmodule
`default_nettype wire
